// [tb_two_bank_led_dimmer_control.sv]
`timescale 1ns/10ps
`include "tbldc_defs.vh"
module tb_two_bank_led_dimmer_control;
  reg        ref_clk = 1'b0;
  reg        reset_n = 1'b1;
  reg        enable_n_pin = 1'b1;
  wire       scl_o, sda_o, sda_oe_r;
  wire [6:0] led_oe_r;
  // Pull-up: released line reads high
  wire       sda_line = sda_o & ~sda_oe_r;
  integer    bad_count = 0, tests_run = 0, i, on0, diff;
  reg  [7:0] rd_d;
  reg        ack;
  always #25 ref_clk = ~ref_clk;
  tbldc_core #(.PERIOD_CYC(1024), .PHASE_DIV(2)) i_dut(.ref_clk(ref_clk), .reset_n(reset_n),
    .enable_n_pin(enable_n_pin), .scl_in(scl_o), .sda_in(sda_line), .sda_oe_r(sda_oe_r),
    .led_oe_r(led_oe_r));
  tbldc_i2c_host i_host(.ref_clk(ref_clk), .sda_line(sda_line), .scl_o(scl_o), .sda_o(sda_o));
  // ****************************************
  // Helpers
  // ****************************************
  task chk(input string nm, input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
      end
    end
  endtask
  task wr(input [3:0] idx, input ai, input [23:0] d, input integer n);
    integer k;
    begin
      i_host.start;
      i_host.wbyte({`TBLDC_DEV_ADDR, 1'b0}, ack);
      i_host.wbyte({3'b000, ai, idx}, ack);
      for (k = 0; k < n; k = k + 1) i_host.wbyte(d[8*k +: 8], ack);
      i_host.stop;
      chk("wr_ack", ack, 8'h00);
    end
  endtask
  task rd(input [3:0] idx);
    begin
      i_host.start;
      i_host.wbyte({`TBLDC_DEV_ADDR, 1'b0}, ack);
      i_host.wbyte({4'h0, idx}, ack);
      i_host.start;
      i_host.wbyte({`TBLDC_DEV_ADDR, 1'b1}, ack);
      i_host.rbyte(1'b1, rd_d);
      i_host.stop;
    end
  endtask
  task watch(input integer n);
    begin
      on0 = 0;
      diff = 0;
      repeat (n) begin
        @(negedge ref_clk);
        on0 = on0 + led_oe_r[0];
        diff = diff + (led_oe_r[0] !== led_oe_r[1]);
      end
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task t_defaults;
    begin
      chk("led_rst", {1'b0, led_oe_r}, 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
        rd(i[3:0]);
        chk("time_def", rd_d, (i < 3) ? `TBLDC_RST_SEL : `TBLDC_RST_TIME);
      end
      rd(`TBLDC_REG_MAX_INT);
      chk("max_def", rd_d, `TBLDC_RST_MAX_INT);
      rd(`TBLDC_REG_MASTER);
      chk("mst_def", rd_d, `TBLDC_RST_MASTER);
    end
  endtask
  task t_regs;
    begin
      wr(`TBLDC_REG_MASTER, 1'b1, 24'h5A0003, 3);
      rd(`TBLDC_REG_MASTER);
      chk("mst_lvl", rd_d, 8'h03);
      rd(`TBLDC_REG_SEL_A);
      chk("wrap", rd_d, 8'h5A);
      for (i = 11; i < 16; i = i + 1) begin
        i_host.start;
        i_host.wbyte({`TBLDC_DEV_ADDR, 1'b0}, ack);
        i_host.wbyte(i[7:0], ack);
        i_host.stop;
        chk("rsv_nak", ack, 8'h01);
      end
    end
  endtask
  task t_master;
    begin
      wr(`TBLDC_REG_SEL_A, 1'b0, 24'h01, 1);
      wr(`TBLDC_REG_SEL_C, 1'b0, 24'h01, 1);
      wr(`TBLDC_REG_MASTER, 1'b0, 24'h0F, 1);
      watch(2048);
      chk("mst_full", on0 == 2048, 8'h01);
      wr(`TBLDC_REG_MASTER, 1'b0, 24'h00, 1);
      watch(2048);
      chk("mst_off", on0 == 0, 8'h01);
      // Level 8 lights 0x88 of 256 slots, 4 cycles each, over two periods
      wr(`TBLDC_REG_MASTER, 1'b0, 24'h08, 1);
      watch(2048);
      chk("mst_half", on0 == 1088, 8'h01);
    end
  endtask
  task t_banks;
    begin
      wr(`TBLDC_REG_SEL_C, 1'b0, 24'h00, 1);
      wr(`TBLDC_REG_SEL_A, 1'b0, 24'h02, 1);
      wr(`TBLDC_REG_SEL_B, 1'b0, 24'h03, 1);
      watch(40000);
      chk("blink", on0 > 0 && on0 < 40000, 8'h01);
      chk("aligned", diff == 0, 8'h01);
    end
  endtask
  task t_shutdown;
    begin
      wr(`TBLDC_REG_SEL_B, 1'b0, 24'h00, 1);
      wr(`TBLDC_REG_SEL_A, 1'b0, 24'h00, 1);
      wr(`TBLDC_REG_SEL_C, 1'b0, 24'h7F, 1);
      repeat (8) @(negedge ref_clk);
      chk("all_on", led_oe_r == 7'h7F, 8'h01);
      enable_n_pin = 1'b0;
      repeat (10) @(negedge ref_clk);
      chk("shut_led", led_oe_r == 7'h00, 8'h01);
      enable_n_pin = 1'b1;
      repeat (4) @(negedge ref_clk);
      rd(`TBLDC_REG_SEL_C);
      chk("shut_rst", rd_d, 8'h00);
    end
  endtask
  initial begin
    // Real falling edge so the flops reset before the first clock
    #1 reset_n = 1'b0;
    repeat (3) @(negedge ref_clk);
    reset_n = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_defaults;
    t_regs;
    t_master;
    t_banks;
    t_shutdown;
    stop_test;
  end
  initial begin
    #4000000;
    bad_count = bad_count + 1;
    stop_test;
  end
endmodule

// [tbldc_core.v]
`timescale 1ns/10ps
`include "tbldc_defs.vh"
// Summary of operation
// - Each of seven outputs picks one of eight modes from three select registers.
// - After reset every output is released, not driven low.
// - Outputs form two banks with independent rate and intensity.
// - Intensity is duty cycle of an about 8 ms period waveform.
// - Two dimming engines on one timebase; engine n drives bank n.
// - Select mode 5 drives an output from the master wave instead of a bank engine.
// - Programmed master level replaces both engines' maximum intensity.
// - Master level is the low four bits of the one-shot/master register.
// - Enable low means shutdown with all LEDs off.
// - Enable low resets all registers and the bus state machine.
// - Every timing field defaults to 256 ms.
// - Maximum intensity has 16 steps from off to fully on.
// - Fades step one of 256 duty levels per period.
// - Unused outputs act as software open-drain outputs.
// - Outputs support on, off, blink and fade at programmed rates.
// - Address byte bit 0: one reads, zero writes.
// - With auto-increment set, index advances per written byte, wraps after init.
// - Command bytes naming reserved indices are not acknowledged.
module tbldc_core #(
  parameter PERIOD_CYC = `TBLDC_PERIOD_CYC,
  parameter PHASE_DIV  = `TBLDC_STEP_PERIODS
) (
  input  wire       ref_clk,
  input  wire       reset_n,
  input  wire       enable_n_pin,
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_oe_r,
  output reg  [6:0] led_oe_r
);
// ****************************************
// Synchronisers
// ****************************************
reg [1:0] scl_s_r, sda_s_r, en_s_r;
reg       scl_d_r, sda_d_r;
always @(posedge ref_clk or negedge reset_n) begin
  if (!reset_n) begin
    scl_s_r <= 2'h3;
    sda_s_r <= 2'h3;
    en_s_r  <= 2'h0;
    scl_d_r <= 1'b1;
    sda_d_r <= 1'b1;
  end else begin
    scl_s_r <= {scl_s_r[0], scl_in};
    sda_s_r <= {sda_s_r[0], sda_in};
    en_s_r  <= {en_s_r[0], enable_n_pin};
    scl_d_r <= scl_s_r[1];
    sda_d_r <= sda_s_r[1];
  end
end
wire scl = scl_s_r[1];
wire sda = sda_s_r[1];
wire en  = en_s_r[1];
wire scl_rise = scl & ~scl_d_r;
wire scl_fall = ~scl & scl_d_r;
wire start_c  = scl & scl_d_r & sda_d_r & ~sda;
wire stop_c   = scl & scl_d_r & ~sda_d_r & sda;
// ****************************************
// Bus state machine and registers
// ****************************************
localparam ST_IDLE = 3'h0;
localparam ST_ADDR = 3'h1;
localparam ST_CMD  = 3'h2;
localparam ST_DATA = 3'h3;
localparam ST_RD   = 3'h4;
localparam ST_SKIP = 3'h5;
reg [2:0] st_r;
reg [3:0] bit_r;
reg [7:0] sh_r;
reg       ack_r;
reg       rd_ack_r;
reg [3:0] idx_r;
reg       ainc_r;
reg [7:0] regs_r [0:9];
reg [7:0] rd_sh_r;
integer   i;
wire [7:0] byte_in = {sh_r[6:0], sda};
always @(posedge ref_clk or negedge reset_n) begin
  if (!reset_n) begin
    st_r <= ST_IDLE; bit_r <= 4'h0; sh_r <= 8'h00; ack_r <= 1'b0;
    rd_ack_r <= 1'b0; idx_r <= 4'h0; ainc_r <= 1'b0; rd_sh_r <= 8'h00;
    sda_oe_r <= 1'b0;
    for (i = 0; i < 10; i = i + 1) regs_r[i] <= 8'h00;
  end else if (!en) begin
    st_r <= ST_IDLE; bit_r <= 4'h0; ack_r <= 1'b0; idx_r <= 4'h0;
    ainc_r <= 1'b0; sda_oe_r <= 1'b0; rd_ack_r <= 1'b0;
    for (i = 0; i < 3; i = i + 1) regs_r[i] <= `TBLDC_RST_SEL;
    for (i = 3; i < 8; i = i + 1) regs_r[i] <= `TBLDC_RST_TIME;
    regs_r[8] <= `TBLDC_RST_MAX_INT;
    regs_r[9] <= `TBLDC_RST_MASTER;
  end else if (start_c) begin
    st_r <= ST_ADDR; bit_r <= 4'h0; ack_r <= 1'b0; sda_oe_r <= 1'b0;
  end else if (stop_c) begin
    st_r <= ST_IDLE; ack_r <= 1'b0; sda_oe_r <= 1'b0;
  end else if (scl_rise) begin
    if (ack_r) begin
      rd_ack_r <= sda;
    end else if (st_r != ST_IDLE && st_r != ST_SKIP && st_r != ST_RD) begin
      sh_r <= byte_in;
      bit_r <= bit_r + 4'h1;
    end
  end else if (scl_fall) begin
    if (ack_r) begin
      ack_r <= 1'b0; sda_oe_r <= 1'b0; bit_r <= 4'h0;
      if (st_r == ST_RD) begin
        if (rd_ack_r) st_r <= ST_SKIP;
        else begin
          rd_sh_r <= (idx_r < 4'hA) ? regs_r[idx_r] : 8'h00;
          sda_oe_r <= (idx_r < 4'hA) ? ~regs_r[idx_r][7] : 1'b0;
        end
      end
    end else if (st_r == ST_RD) begin
      if (bit_r == 4'h7) begin
        bit_r <= 4'h0; ack_r <= 1'b1; sda_oe_r <= 1'b0; rd_ack_r <= 1'b0;
      end else begin
        bit_r <= bit_r + 4'h1;
        rd_sh_r <= {rd_sh_r[6:0], 1'b0};
        sda_oe_r <= ~rd_sh_r[6];
      end
    end else if (bit_r == 4'h8) begin
      bit_r <= 4'h0;
      case (st_r)
        ST_ADDR: begin
          if (sh_r[7:1] == `TBLDC_DEV_ADDR) begin
            ack_r <= 1'b1; sda_oe_r <= 1'b1;
            st_r <= sh_r[`TBLDC_RW_BIT] ? ST_RD : ST_CMD;
            if (sh_r[`TBLDC_RW_BIT]) rd_sh_r <= (idx_r < 4'hA) ? regs_r[idx_r] : 8'h00;
          end else st_r <= ST_SKIP;
        end
        ST_CMD: begin
          if (sh_r[3:0] > `TBLDC_REG_LAST) st_r <= ST_SKIP;
          else begin
            ack_r <= 1'b1; sda_oe_r <= 1'b1; st_r <= ST_DATA;
            idx_r <= sh_r[3:0]; ainc_r <= sh_r[`TBLDC_AUTO_INC_BIT];
          end
        end
        ST_DATA: begin
          ack_r <= 1'b1; sda_oe_r <= 1'b1;
          if (idx_r < `TBLDC_REG_INIT) regs_r[idx_r] <= sh_r;
          if (ainc_r) idx_r <= (idx_r == `TBLDC_REG_LAST) ? 4'h0 : idx_r + 4'h1;
        end
        default: st_r <= ST_SKIP;
      endcase
    end
  end else if (st_r == ST_RD && bit_r == 4'h0 && !ack_r && sda_oe_r == 1'b0
               && scl_d_r == 1'b0 && rd_sh_r[7] == 1'b0 && !rd_ack_r) begin
    sda_oe_r <= 1'b1;
  end
end
// ****************************************
// Shared period counter and engines
// ****************************************
localparam SLOT_CYC = PERIOD_CYC / `TBLDC_DUTY_SLOTS;
reg  [15:0] slot_cnt_r;
reg  [7:0]  duty_pos_r;
reg  [7:0]  phase_div_r;
// Period split into 256 equal duty slots, whatever the clock
wire        slot_end = (slot_cnt_r == SLOT_CYC - 1);
wire        per_end  = slot_end && (duty_pos_r == 8'hFF);
wire        tick     = per_end && (phase_div_r == PHASE_DIV - 1);
always @(posedge ref_clk or negedge reset_n) begin
  if (!reset_n) begin
    slot_cnt_r <= 16'h0000;
    duty_pos_r <= 8'h00;
    phase_div_r <= 8'h00;
  end else if (!en) begin
    slot_cnt_r <= 16'h0000;
    duty_pos_r <= 8'h00;
    phase_div_r <= 8'h00;
  end else begin
    slot_cnt_r <= slot_end ? 16'h0000 : slot_cnt_r + 16'h0001;
    if (slot_end)
      duty_pos_r <= duty_pos_r + 8'h01;
    if (per_end)
      phase_div_r <= tick ? 8'h00 : phase_div_r + 8'h01;
  end
end
wire [7:0] duty_pos = duty_pos_r;
wire [3:0] master_lvl = regs_r[9][3:0];
wire       master_max = regs_r[9][7];
// Top level must light every slot, so level 15 is forced fully on
wire       master_wave = (master_lvl == 4'hF) || ({master_lvl, master_lvl} > duty_pos);
wire [1:0] eng_wave;
genvar g;
generate for (g = 0; g < 2; g = g + 1) begin : eng
  reg  [1:0] ph_r;
  reg  [7:0] lvl_r;
  reg  [3:0] tmr_r;
  reg        wave_r;
  wire [3:0] maxi = master_max ? master_lvl :
                    (g == 0 ? regs_r[8][3:0] : regs_r[8][7:4]);
  wire [7:0] top  = {maxi, maxi};
  wire [7:0] tfld = regs_r[3 + ph_r];
  wire [3:0] tsel = (g == 0) ? tfld[3:0] : tfld[7:4];
  assign eng_wave[g] = wave_r;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_r <= 2'h0;
      lvl_r <= 8'h00;
      tmr_r <= 4'h0;
      wave_r <= 1'b0;
    end else if (!en) begin
      ph_r <= 2'h0;
      lvl_r <= 8'h00;
      tmr_r <= 4'h0;
      wave_r <= 1'b0;
    end else begin
      wave_r <= (lvl_r == 8'hFF) || (lvl_r > duty_pos);
      if (per_end && ph_r == 2'h0 && lvl_r < top)
        lvl_r <= lvl_r + 8'h01;
      else if (per_end && ph_r == 2'h2 && lvl_r != 8'h00)
        lvl_r <= lvl_r - 8'h01;
      else if (ph_r == 2'h1)
        lvl_r <= top;
      else if (ph_r == 2'h3)
        lvl_r <= 8'h00;
      if (tick) begin
        // Field counts quarter steps: the default of 4 gives 256 ms
        if ({1'b0, tmr_r} + 5'h01 >= {1'b0, tsel}) begin
          tmr_r <= 4'h0;
          ph_r <= ph_r + 2'h1;
        end else begin
          tmr_r <= tmr_r + 4'h1;
        end
      end
    end
  end
end endgenerate
// ****************************************
// Output mode select
// ****************************************
reg [6:0] drive_nxt;
reg [2:0] mode;
integer   k;
always @* begin
  drive_nxt = 7'h00;
  mode = 3'h0;
  for (k = 0; k < 7; k = k + 1) begin
    mode = {regs_r[2][k], regs_r[1][k], regs_r[0][k]};
    case (mode)
      3'h0, 3'h1: drive_nxt[k] = 1'b0;
      3'h2:       drive_nxt[k] = eng_wave[0];
      3'h3:       drive_nxt[k] = eng_wave[1];
      3'h4:       drive_nxt[k] = 1'b1;
      3'h5:       drive_nxt[k] = master_wave;
      3'h6:       drive_nxt[k] = eng_wave[0];
      default:    drive_nxt[k] = eng_wave[1];
    endcase
  end
end
always @(posedge ref_clk or negedge reset_n) begin
  if (!reset_n) led_oe_r <= 7'h00;
  else led_oe_r <= en ? drive_nxt : 7'h00;
end
endmodule

// [tbldc_core_props.sv]
`timescale 1ns/10ps
module tbldc_core_props(
  input wire       ref_clk,
  input wire       reset_n,
  input wire       enable_n_pin,
  input wire       scl_in,
  input wire       sda_in,
  input wire       sda_oe_r,
  input wire [6:0] led_oe_r
);
  reg [3:0] low_ago_r;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) low_ago_r <= 4'hF;
    else if (!scl_in) low_ago_r <= 4'h0;
    else if (low_ago_r != 4'hF) low_ago_r <= low_ago_r + 4'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  property p_rst_out;
    disable iff (1'b0) !reset_n |-> led_oe_r == 7'h00 && !sda_oe_r;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs active in reset");
  property p_rst_rel; $rose(reset_n) |-> !sda_oe_r [*3]; endproperty
  a_rst_rel: assert property (p_rst_rel) else $error("sda driven after reset");
  property p_shut_led; !enable_n_pin [*6] |-> led_oe_r == 7'h00; endproperty
  a_shut_led: assert property (p_shut_led) else $error("led on in shutdown");
  property p_shut_sda; !enable_n_pin [*6] |-> !sda_oe_r; endproperty
  a_shut_sda: assert property (p_shut_sda) else $error("bus active in shutdown");
  property p_en_rel; $rose(enable_n_pin) |-> led_oe_r == 7'h00 [*8]; endproperty
  a_en_rel: assert property (p_en_rel) else $error("led on after shutdown");
  property p_oe_rise; $rose(sda_oe_r) |-> low_ago_r < 4'h6; endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("sda pulled off scl low");
  property p_oe_fall; $fell(sda_oe_r) |-> low_ago_r < 4'h6; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("sda freed off scl low");
  property p_ack_hold; sda_oe_r && $rose(scl_in) |=> sda_oe_r [*2]; endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("sda dropped in scl high");
  c_start: cover property ($fell(sda_in) && scl_in);
  c_ack: cover property ($rose(sda_oe_r));
  c_led: cover property (led_oe_r == 7'h7F);
endmodule
bind tbldc_core tbldc_core_props i_props(.ref_clk(ref_clk), .reset_n(reset_n),
  .enable_n_pin(enable_n_pin), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_r(sda_oe_r),
  .led_oe_r(led_oe_r));

// [tbldc_defs.vh]
`ifndef TBLDC_DEFS_VH
`define TBLDC_DEFS_VH
// ****************************************
// Register indices
// ****************************************
`define TBLDC_REG_SEL_A     4'h0
`define TBLDC_REG_SEL_B     4'h1
`define TBLDC_REG_SEL_C     4'h2
`define TBLDC_REG_FADE_ON   4'h3
`define TBLDC_REG_FULL_ON   4'h4
`define TBLDC_REG_FADE_OFF  4'h5
`define TBLDC_REG_OFF_ONE   4'h6
`define TBLDC_REG_OFF_TWO   4'h7
`define TBLDC_REG_MAX_INT   4'h8
`define TBLDC_REG_MASTER    4'h9
`define TBLDC_REG_INIT      4'hA
`define TBLDC_REG_LAST      4'hA
// ****************************************
// Reset values
// ****************************************
`define TBLDC_RST_SEL       8'h00
`define TBLDC_RST_TIME      8'h44
`define TBLDC_RST_MAX_INT   8'hFF
`define TBLDC_RST_MASTER    8'h0F
// ****************************************
// Bus fields and timing
// ****************************************
`define TBLDC_DEV_ADDR      7'h45
`define TBLDC_AUTO_INC_BIT  4
`define TBLDC_RW_BIT        0
`define TBLDC_CLK_HZ        20000000
`define TBLDC_PERIOD_US     8000
`define TBLDC_PERIOD_CYC    ((`TBLDC_CLK_HZ / 1000000) * `TBLDC_PERIOD_US)
`define TBLDC_PHASE_MS      256
`define TBLDC_PHASE_PERIODS (`TBLDC_PHASE_MS * 1000 / `TBLDC_PERIOD_US)
`define TBLDC_TIME_STEPS    4
`define TBLDC_STEP_PERIODS  (`TBLDC_PHASE_PERIODS / `TBLDC_TIME_STEPS)
`define TBLDC_DUTY_SLOTS    256
`endif

// [tbldc_i2c_host.sv]
`timescale 1ns/10ps
module tbldc_i2c_host(
  input  wire ref_clk,
  input  wire sda_line,
  output reg  scl_o,
  output reg  sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task q;
    repeat (2) @(negedge ref_clk);
  endtask
  // Sample just before the fall: device answers lag the pin by its sync
  task bit_x(input b, output r);
    begin
      sda_o = b;
      q;
      scl_o = 1'b1;
      q;
      q;
      r = sda_line;
      scl_o = 1'b0;
      q;
    end
  endtask
  task start;
    begin
      sda_o = 1'b1;
      q;
      q;
      scl_o = 1'b1;
      q;
      sda_o = 1'b0;
      q;
      scl_o = 1'b0;
      q;
    end
  endtask
  task stop;
    begin
      sda_o = 1'b0;
      q;
      scl_o = 1'b1;
      q;
      sda_o = 1'b1;
      q;
    end
  endtask
  task wbyte(input [7:0] d, output a);
    integer k;
    reg     r;
    begin
      for (k = 7; k >= 0; k = k - 1) bit_x(d[k], r);
      bit_x(1'b1, a);
    end
  endtask
  task rbyte(input nk, output [7:0] d);
    integer k;
    reg     r;
    begin
      for (k = 7; k >= 0; k = k - 1) bit_x(1'b1, d[k]);
      bit_x(nk, r);
    end
  endtask
endmodule
